// ===== include/tcu_consts.svh
// timing channel unit constants: register offsets, field selects, reset values, counts
// assumes byte addresses on an 8-bit apb address with one aligned word per register
`ifndef TCU_CONSTS_SVH
`define TCU_CONSTS_SVH
// time base k sits at 8'h10*k; word index within it on paddr[3:2]
`define TCU_TB_CTRL      2'h0
`define TCU_TB_COUNT     2'h1
`define TCU_TB_RELOAD    2'h2
// miscellaneous block at 8'h20, word index on paddr[3:2]
`define TCU_MISC_SEL     4'h2
`define TCU_UNIT_CTRL    2'h0
`define TCU_IRQ_STATUS   2'h1
`define TCU_IRQ_CLEAR    2'h2
`define TCU_IRQ_ENABLE   2'h3
// channel config at 8'h40 + 4*ch, channel value at 8'h80 + 4*ch (paddr[7:6])
`define TCU_CH_CFG_SEL   2'h1
`define TCU_CH_VAL_SEL   2'h2
// staggered operation: one slot in eight cycles
`define TCU_STAGGER_LAST 3'h7
`define TCU_COUNT_MAX    16'hffff
`define TCU_IRQ_W        18
`define TCU_RST_WORD     32'h0000_0000
`endif

// ===== include/tcu_pkg.sv
// timing channel unit types: modes, clock sources, register regions, state carriers
// assumes tcu_consts.svh is on the include path
`default_nettype none
`include "tcu_consts.svh"
package tcu_pkg;
  typedef enum logic [2:0] {
    TCU_OFF = 3'h0, TCU_CAP_RISE = 3'h1, TCU_CAP_FALL = 3'h2, TCU_CAP_BOTH = 3'h3,
    TCU_CMP0 = 3'h4, TCU_CMP1 = 3'h5, TCU_CMP2 = 3'h6, TCU_CMP3 = 3'h7
  } tcu_mode_type;
  typedef enum logic [1:0] {
    TCU_SRC_PRESCALE = 2'h0, TCU_SRC_GT_OVF = 2'h1, TCU_SRC_EXT = 2'h2, TCU_SRC_STOP = 2'h3
  } tcu_src_type;
  typedef enum logic [3:0] {
    TCU_R_NONE = 4'h0, TCU_R_TB_CTRL = 4'h1, TCU_R_TB_COUNT = 4'h2, TCU_R_TB_RELOAD = 4'h3,
    TCU_R_UNIT = 4'h4, TCU_R_STATUS = 4'h5, TCU_R_CLEAR = 4'h6, TCU_R_ENABLE = 4'h7,
    TCU_R_CFG = 4'h8, TCU_R_VAL = 4'h9
  } tcu_region_type;
  typedef struct packed {
    logic [2:0]  pre;
    tcu_src_type src;
    logic        run;
  } tcu_tb_ctrl_type;
  typedef struct packed {
    logic         dbl;
    logic         single;
    logic         tsel;
    tcu_mode_type mode;
  } tcu_ch_cfg_type;
  typedef struct packed {
    logic        wr_count;
    logic        wr_reload;
    logic [15:0] wdata;
  } tcu_tb_wr_type;
  typedef struct packed {
    logic [15:0] count;
    logic [15:0] reload;
    logic        ovf;
    logic        step;
  } tcu_tb_out_type;
  typedef struct packed {
    tcu_tb_out_type o;
    logic [6:0]     pre_cnt;
    logic           ext_prev;
  } tcu_tb_state_type;
  typedef struct packed {
    logic [`TCU_IRQ_W-1:0] status;
    logic [`TCU_IRQ_W-1:0] enable;
    logic                  irq;
  } tcu_irq_state_type;
  typedef struct packed {
    tcu_tb_ctrl_type [1:0]  tb_ctrl;
    logic                   stagger;
    logic [2:0]             stag_cnt;
    tcu_ch_cfg_type [15:0]  cfg;
    logic [15:0][15:0]      val;
    logic [15:0]            pin_prev;
    logic [15:0]            pin_out;
    logic [15:0]            pin_oe;
    logic [15:0]            done;
    logic [15:0]            spent;
    logic [31:0]            prdata;
    logic                   pready;
    logic                   pslverr;
  } tcu_top_state_type;
endpackage : tcu_pkg
`default_nettype wire

// ===== logic/tcu_timebase.sv
// one 16-bit up-counting time base with reload and selectable count source
// assumes count inputs synchronous to clock; writes come as one-cycle strobes
`timescale 1ns/1ps
`default_nettype none
`include "tcu_consts.svh"
module tcu_timebase
  import tcu_pkg::*;
(
  input  wire logic            clock,
  input  wire logic            rst,
  input  wire tcu_tb_ctrl_type ctrl,
  input  wire logic            stag_ok,
  input  wire logic            gt_ovf,
  input  wire logic            ext_cnt,
  input  wire tcu_tb_wr_type   wr,
  output var  tcu_tb_out_type  tb
);
  tcu_tb_state_type s, n;
  logic [7:0]       pmask;
  logic             tick;

  // source select, then count or reload; software write of the count wins over a tick
  always_comb begin
    n = s;
    tick = 1'b0;
    n.o.ovf = 1'b0;
    n.o.step = 1'b0;
    n.ext_prev = ext_cnt;
    pmask = 8'((8'h1 << ctrl.pre) - 8'h1);
    if (stag_ok) n.pre_cnt = s.pre_cnt + 7'h1; // prescaler only advances on slots
    unique case (ctrl.src)
      TCU_SRC_PRESCALE: tick = stag_ok && ((s.pre_cnt & pmask[6:0]) == pmask[6:0]);
      TCU_SRC_GT_OVF:   tick = gt_ovf;
      TCU_SRC_EXT:      tick = ext_cnt && !s.ext_prev;
      TCU_SRC_STOP:     tick = 1'b0;
    endcase
    tick = tick && ctrl.run;
    if (wr.wr_count) begin
      n.o.count = wr.wdata;
    end else if (tick) begin
      n.o.step = 1'b1;
      if (s.o.count == `TCU_COUNT_MAX) begin
        n.o.count = s.o.reload;
        n.o.ovf = 1'b1;
      end else begin
        n.o.count = s.o.count + 16'h1;
      end
    end
    if (wr.wr_reload) n.o.reload = wr.wdata;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) s <= '0;
    else s <= n;
  end

  assign tb = s.o;

  chk_reload_load: assert property (@(posedge clock) disable iff (rst)
    (tick && !wr.wr_count && s.o.count == `TCU_COUNT_MAX)
      |=> (s.o.count == $past(s.o.reload) && s.o.ovf))
    else $error("time base did not reload on overflow");
  chk_count_step: assert property (@(posedge clock) disable iff (rst)
    (tick && !wr.wr_count && s.o.count != `TCU_COUNT_MAX)
      |=> (s.o.count == $past(s.o.count) + 16'h1 && s.o.step && !s.o.ovf))
    else $error("time base did not advance by one");
endmodule : tcu_timebase
`default_nettype wire

// ===== logic/tcu_irq.sv
// sticky interrupt status with write-one-to-clear, enable mask and one level output
// assumes set events are one-cycle pulses; a set in the clearing cycle wins
`timescale 1ns/1ps
`default_nettype none
`include "tcu_consts.svh"
module tcu_irq
  import tcu_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire logic [`TCU_IRQ_W-1:0] set_ev,
  input  wire logic                  clr_wr,
  input  wire logic                  en_wr,
  input  wire logic [`TCU_IRQ_W-1:0] wdata,
  output var  logic [`TCU_IRQ_W-1:0] status,
  output var  logic [`TCU_IRQ_W-1:0] enable,
  output var  logic                  irq
);
  tcu_irq_state_type s, n;

  // irq follows the next status so it rises with the status bit, not a cycle later
  always_comb begin
    n = s;
    n.status = (s.status & ~(clr_wr ? wdata : '0)) | set_ev;
    if (en_wr) n.enable = wdata;
    n.irq = |(n.status & n.enable);
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) s <= '0;
    else s <= n;
  end

  assign status = s.status;
  assign enable = s.enable;
  assign irq    = s.irq;

  chk_irq_level: assert property (@(posedge clock) disable iff (rst)
    s.irq == |(s.status & s.enable))
    else $error("interrupt level disagrees with status and enable");
  chk_set_wins: assert property (@(posedge clock) disable iff (rst)
    1'b1 |=> ((s.status & $past(set_ev)) == $past(set_ev)))
    else $error("event lost against a clear");
endmodule : tcu_irq
`default_nettype wire

// ===== logic/tcu_top.sv
// timing channel unit: two time bases, sixteen capture/compare channels, apb registers
// assumes pins and count inputs synchronous to clock; apb master per the usual protocol
//
// Notes on behaviour
// - one-cycle resolution, eight cycles for the prescaler when staggered
// - two 16-bit time bases with reload registers
// - time base clock: prescaler, timer overflow, pin
// - each channel picks time base and function
// - each channel owns one pin, input or output
// - capture copies time base, raises channel interrupt
// - capture edge: rising, falling or both
// - compare channels match against time base on each step
// - mode 0: interrupt only, repeatable per period
// - mode 1: pin toggles on every match, except one that lands with a paired toggle in the same cycle
// - mode 2: interrupt only, once per period
// - mode 3: set on match, clear on overflow
// - double register: two channels toggle one pin
// - single event: one edge or pulse only
`timescale 1ns/1ps
`default_nettype none
`include "tcu_consts.svh"
module tcu_top
  import tcu_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic [15:0] pin_in,
  output var  logic [15:0] pin_out,
  output var  logic [15:0] pin_oe,
  input  wire logic        external_prescale_timer_ovf,
  input  wire logic [1:0]  ext_count_in,
  output var  logic        irq
);
  tcu_top_state_type     s, n;
  tcu_tb_out_type [1:0]  tb;
  tcu_tb_wr_type [1:0]   tb_wr;
  tcu_region_type        rg;
  logic [15:0][15:0]     cap_src;
  logic [15:0]           cap_ev;
  logic [15:0]           hit;
  logic [15:0]           tovf;
  logic [15:0]           rt;
  logic [15:0]           own_tog;
  logic [15:0]           dbl_tog;
  logic [15:0]           evt;
  logic [`TCU_IRQ_W-1:0] set_ev;
  logic [`TCU_IRQ_W-1:0] irq_status;
  logic [`TCU_IRQ_W-1:0] irq_enable;
  logic                  acc;
  logic                  wr_go;
  logic                  stag_ok;
  logic                  clr_wr;
  logic                  en_wr;
  logic [3:0]            k;
  logic                  idx;

  // address to register region; misaligned or unused words map to none
  function automatic tcu_region_type tcu_decode(input logic [7:0] a);
    tcu_region_type r;
    r = TCU_R_NONE;
    if (a[1:0] == 2'h0) begin
      if (a[7:6] == `TCU_CH_CFG_SEL) begin
        r = TCU_R_CFG;
      end else if (a[7:6] == `TCU_CH_VAL_SEL) begin
        r = TCU_R_VAL;
      end else if (a[7:5] == 3'h0) begin
        if (a[3:2] == `TCU_TB_CTRL) r = TCU_R_TB_CTRL;
        else if (a[3:2] == `TCU_TB_COUNT) r = TCU_R_TB_COUNT;
        else if (a[3:2] == `TCU_TB_RELOAD) r = TCU_R_TB_RELOAD;
      end else if (a[7:4] == `TCU_MISC_SEL) begin
        if (a[3:2] == `TCU_UNIT_CTRL) r = TCU_R_UNIT;
        else if (a[3:2] == `TCU_IRQ_STATUS) r = TCU_R_STATUS;
        else if (a[3:2] == `TCU_IRQ_CLEAR) r = TCU_R_CLEAR;
        else r = TCU_R_ENABLE;
      end
    end
    return r;
  endfunction : tcu_decode

  // compare modes all carry the top mode bit
  function automatic logic tcu_is_cmp(input tcu_mode_type m);
    return m[2];
  endfunction : tcu_is_cmp

  // capture trigger from the chosen edge of the pin
  function automatic logic tcu_edge(input tcu_mode_type m, input logic p, input logic c);
    return (m == TCU_CAP_RISE && !p && c) || (m == TCU_CAP_FALL && p && !c)
        || (m == TCU_CAP_BOTH && p != c);
  endfunction : tcu_edge

  // the two time bases share the general timer overflow; each has its own count pin
  for (genvar t = 0; t < 2; t++) begin : g_tb
    tcu_timebase u_tb (
      .clock   (clock),
      .rst     (rst),
      .ctrl    (s.tb_ctrl[t]),
      .stag_ok (stag_ok),
      .gt_ovf  (external_prescale_timer_ovf),
      .ext_cnt (ext_count_in[t]),
      .wr      (tb_wr[t]),
      .tb      (tb[t])
    );
  end

  // channels 0..15 on status bits 0..15, time base overflows on 16 and 17
  tcu_irq u_irq (
    .clock  (clock),
    .rst    (rst),
    .set_ev (set_ev),
    .clr_wr (clr_wr),
    .en_wr  (en_wr),
    .wdata  (pwdata[`TCU_IRQ_W-1:0]),
    .status (irq_status),
    .enable (irq_enable),
    .irq    (irq)
  );

  // bus slave, then channel work; a capture wins over a software write of the same value
  always_comb begin
    n = s;
    cap_src = '0;
    cap_ev = '0;
    hit = '0;
    tovf = '0;
    rt = '0;
    own_tog = '0;
    dbl_tog = '0;
    evt = '0;
    clr_wr = 1'b0;
    en_wr = 1'b0;
    rg = tcu_decode(paddr);
    k = paddr[5:2];
    idx = paddr[4];
    acc = psel && penable;
    wr_go = acc && s.pready && pwrite;
    tb_wr[0] = '{wr_count: 1'b0, wr_reload: 1'b0, wdata: pwdata[15:0]};
    tb_wr[1] = '{wr_count: 1'b0, wr_reload: 1'b0, wdata: pwdata[15:0]};
    // staggered slots cut the prescaled rate eightfold: the prescaler advances on one slot in eight cycles
    stag_ok = !s.stagger || s.stag_cnt == `TCU_STAGGER_LAST;
    n.stag_cnt = s.stag_cnt + 3'h1;
    n.pin_prev = pin_in;

    // one wait state: read data and error are built in the first access cycle
    n.pready = acc && !s.pready;
    n.pslverr = 1'b0;
    n.prdata = `TCU_RST_WORD;
    if (acc && !s.pready) begin
      n.pslverr = (rg == TCU_R_NONE);
      unique case (rg)
        TCU_R_TB_CTRL:   n.prdata = {26'h0, s.tb_ctrl[idx]};
        TCU_R_TB_COUNT:  n.prdata = {16'h0, tb[idx].count};
        TCU_R_TB_RELOAD: n.prdata = {16'h0, tb[idx].reload};
        TCU_R_UNIT:      n.prdata = {31'h0, s.stagger};
        TCU_R_STATUS:    n.prdata = {14'h0, irq_status};
        TCU_R_ENABLE:    n.prdata = {14'h0, irq_enable};
        TCU_R_CFG:       n.prdata = {26'h0, s.cfg[k]};
        TCU_R_VAL:       n.prdata = {16'h0, s.val[k]};
        TCU_R_NONE, TCU_R_CLEAR: n.prdata = `TCU_RST_WORD;
      endcase
    end
    if (wr_go) begin
      unique case (rg)
        TCU_R_TB_CTRL:   n.tb_ctrl[idx] = tcu_tb_ctrl_type'(pwdata[5:0]);
        TCU_R_TB_COUNT:  tb_wr[idx].wr_count = 1'b1;
        TCU_R_TB_RELOAD: tb_wr[idx].wr_reload = 1'b1;
        TCU_R_UNIT:      n.stagger = pwdata[0];
        TCU_R_CLEAR:     clr_wr = 1'b1;
        TCU_R_ENABLE:    en_wr = 1'b1;
        TCU_R_CFG: begin
          n.cfg[k] = tcu_ch_cfg_type'(pwdata[5:0]);
          n.spent[k] = 1'b0; // rearms single event
          n.done[k] = 1'b0;
        end
        TCU_R_VAL:       n.val[k] = pwdata[15:0];
        TCU_R_NONE, TCU_R_STATUS: n.done = n.done;
      endcase
    end

    // per channel: trigger detect and qualified match against its time base
    for (int i = 0; i < 16; i++) begin
      cap_src[i] = tb[s.cfg[i].tsel].count;
      tovf[i] = tb[s.cfg[i].tsel].ovf;
      rt[i] = (i >= 8) && s.cfg[i].dbl && tcu_is_cmp(s.cfg[i].mode);
      cap_ev[i] = tcu_edge(s.cfg[i].mode, s.pin_prev[i], pin_in[i]);
      // a match counts only on the cycle the time base stepped, so a stopped base
      // sitting on the compare value does not fire every cycle
      hit[i] = tcu_is_cmp(s.cfg[i].mode) && tb[s.cfg[i].tsel].step
            && cap_src[i] == s.val[i] && !s.spent[i];
    end
    // a paired upper channel toggles the pin of the channel eight below it
    for (int i = 0; i < 8; i++) begin
      dbl_tog[i] = hit[i + 8] && rt[i + 8];
    end

    for (int i = 0; i < 16; i++) begin
      if (cap_ev[i]) begin
        n.val[i] = cap_src[i];
        evt[i] = 1'b1;
      end
      if (tcu_is_cmp(s.cfg[i].mode)) begin
        if (tovf[i]) n.done[i] = 1'b0; // new period rearms modes 2 and 3
        if (s.cfg[i].mode == TCU_CMP3 && tovf[i] && !rt[i]) begin
          n.pin_out[i] = 1'b0;
        end
        if (hit[i]) begin
          if (rt[i]) begin
            evt[i] = 1'b1;
          end else if (s.cfg[i].mode == TCU_CMP0) begin
            evt[i] = 1'b1;
          end else if (s.cfg[i].mode == TCU_CMP1) begin
            own_tog[i] = 1'b1;
            evt[i] = 1'b1;
          end else if (!n.done[i]) begin
            n.done[i] = 1'b1;
            evt[i] = 1'b1;
            if (s.cfg[i].mode == TCU_CMP3) n.pin_out[i] = 1'b1;
          end
        end
        if (s.cfg[i].single && evt[i]) n.spent[i] = 1'b1;
      end
      n.pin_oe[i] = tcu_is_cmp(s.cfg[i].mode) && !rt[i];
    end
    for (int i = 0; i < 8; i++) begin
      n.pin_oe[i] = n.pin_oe[i] || rt[i + 8];
    end
    // both toggles in one cycle cancel, as two inversions would
    n.pin_out = n.pin_out ^ own_tog ^ dbl_tog;
    set_ev = {tb[1].ovf, tb[0].ovf, evt};
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) s <= '0;
    else s <= n;
  end

  // outputs straight from state flops
  assign prdata  = s.prdata;
  assign pready  = s.pready;
  assign pslverr = s.pslverr;
  assign pin_out = s.pin_out;
  assign pin_oe  = s.pin_oe;

  chk_pready_pulse: assert property (@(posedge clock) disable iff (rst)
    s.pready |=> !s.pready)
    else $error("pready held longer than one cycle");
  chk_stagger_slot: assert property (@(posedge clock) disable iff (rst)
    (s.stagger && $past(s.stagger) && s.tb_ctrl[0].src == TCU_SRC_PRESCALE
      && $stable(s.tb_ctrl[0]) && tb[0].step) |-> s.stag_cnt == 3'h0)
    else $error("staggered time base stepped outside its slot");

  for (genvar g = 0; g < 16; g++) begin : g_chk
    chk_capture_value: assert property (@(posedge clock) disable iff (rst)
      cap_ev[g] |=> s.val[g] == $past(cap_src[g]))
      else $error("capture did not latch the time base");
    chk_capture_irq: assert property (@(posedge clock) disable iff (rst)
      cap_ev[g] |=> irq_status[g])
      else $error("capture raised no interrupt");
    chk_edge_select: assert property (@(posedge clock) disable iff (rst)
      cap_ev[g] |-> (pin_in[g] != s.pin_prev[g])
        && (s.cfg[g].mode != TCU_CAP_RISE || pin_in[g])
        && (s.cfg[g].mode != TCU_CAP_FALL || !pin_in[g]))
      else $error("capture on the wrong edge");
    chk_mode0_irq: assert property (@(posedge clock) disable iff (rst)
      (hit[g] && s.cfg[g].mode == TCU_CMP0 && !rt[g] && !dbl_tog[g])
        |=> (irq_status[g] && $stable(s.pin_out[g])))
      else $error("mode 0 match mishandled");
    chk_toggle_pin: assert property (@(posedge clock) disable iff (rst)
      (hit[g] && s.cfg[g].mode == TCU_CMP1 && !rt[g] && !dbl_tog[g])
        |=> s.pin_out[g] != $past(s.pin_out[g]))
      else $error("mode 1 match did not toggle the pin");
    chk_double_pin: assert property (@(posedge clock) disable iff (rst)
      (dbl_tog[g] && s.cfg[g].mode == TCU_CMP1 && !hit[g])
        |=> s.pin_out[g] != $past(s.pin_out[g]))
      else $error("paired channel did not toggle the shared pin");
    chk_mode2_once: assert property (@(posedge clock) disable iff (rst)
      (s.cfg[g].mode == TCU_CMP2 && !rt[g] && s.done[g] && !tovf[g]) |-> !evt[g])
      else $error("mode 2 fired twice in one period");
    chk_mode3_set: assert property (@(posedge clock) disable iff (rst)
      (hit[g] && s.cfg[g].mode == TCU_CMP3 && !rt[g] && !s.done[g] && !dbl_tog[g])
        |=> (s.pin_out[g] && s.done[g]))
      else $error("mode 3 match did not set the pin");
    chk_mode3_clear: assert property (@(posedge clock) disable iff (rst)
      (s.cfg[g].mode == TCU_CMP3 && !rt[g] && tovf[g] && !hit[g] && !dbl_tog[g])
        |=> !s.pin_out[g])
      else $error("mode 3 overflow did not clear the pin");
    chk_single_event: assert property (@(posedge clock) disable iff (rst)
      (s.spent[g] && tcu_is_cmp(s.cfg[g].mode)) |-> !evt[g] ##1 !own_tog[g])
      else $error("single event channel fired again");
  end
endmodule : tcu_top
`default_nettype wire

// ===== sim/tcu_pin_model.sv
// far side of the sixteen channel pins: capture levels in, compare levels out
// assumes the bench changes drv just after a rising clock edge
`timescale 1ns/1ps
`default_nettype none
module tcu_pin_model (
  input  wire logic [15:0] pin_out,
  input  wire logic [15:0] pin_oe,
  input  wire logic [15:0] drv,
  output var  logic [15:0] pin_in
);
  // a pin the unit drives reads back its own level, else the outside level
  always_comb begin
    pin_in = (pin_oe & pin_out) | (~pin_oe & drv);
  end
endmodule : tcu_pin_model
`default_nettype wire

// ===== sim/tb.sv
// bench for the timing channel unit: apb master, pin partner, random and corner cases
// assumes the register map of tcu_consts.svh and one 100 ns clock
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        gt_ovf = 1'b0;
  logic [1:0]  ext_cnt = 2'h0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [15:0] drv = 16'h0;
  logic [15:0] prev_pin = 16'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, irq, er;
  logic [15:0] pin_in, pin_out, pin_oe, c, rl;
  int          edges [16] = '{default: 0};
  int          errors = 0;
  int          tests_run = 0;
  int          p, st, n, r;
  logic [7:0]  ra [12] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h18, 8'h20, 8'h24, 8'h28,
                          8'h2c, 8'hbc, 8'hc0, 8'h41};
  int          chs [10] = '{0, 9, 1, 2, 3, 4, 5, 6, 7, 10};
  int          cfgs [10] = '{7, 8'h25, 5, 5, 4, 6, 8'h15, 1, 2, 3};

  // free running system clock
  always #50 clock = ~clock;

  tcu_top dut_u (
    .clock                       (clock),
    .rst                         (rst),
    .psel                        (psel),
    .penable                     (penable),
    .pwrite                      (pwrite),
    .paddr                       (paddr),
    .pwdata                      (pwdata),
    .prdata                      (prdata),
    .pready                      (pready),
    .pslverr                     (pslverr),
    .pin_in                      (pin_in),
    .pin_out                     (pin_out),
    .pin_oe                      (pin_oe),
    .external_prescale_timer_ovf (gt_ovf),
    .ext_count_in                (ext_cnt),
    .irq                         (irq)
  );
  tcu_pin_model pins_u (.pin_out(pin_out), .pin_oe(pin_oe), .drv(drv), .pin_in(pin_in));

  // count pin transitions so toggles can be totalled over whole periods;
  // pins are unknown until the first reset edge, so nothing counts in reset
  always @(posedge clock) begin
    for (int i = 0; i < 16; i++)
      if (!rst && pin_out[i] !== prev_pin[i]) edges[i]++;
    prev_pin <= pin_out;
  end

  // steps seen over 64 cycles: staggering keeps one slot in eight
  function automatic logic [15:0] exp_steps(input int p, input int st);
    return 16'((st != 0 ? 8 : 64) >> p);
  endfunction : exp_steps

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // one apb transfer; an idle edge after it keeps drivers from double assigning
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) begin
      errors++; // no answer on the bus counts as a mismatch
      wrap_up();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb

  // one-cycle count pulses: sel 0 general timer overflow, 1 count input of time base 1
  task automatic tick(input int n, input int sel);
    repeat (n) begin
      {ext_cnt[1], gt_ovf} <= (sel != 0) ? 2'b10 : 2'b01;
      @(posedge clock);
      {ext_cnt[1], gt_ovf} <= 2'b00;
      @(posedge clock);
    end
  endtask : tick

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  // a hang costs a mismatch; the whole run needs under six hundred cycles
  initial begin
    #(100 * 30000);
    errors++;
    wrap_up();
  end

  initial begin
    void'($urandom(32'h1611ddaf));
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    // reset values, ignored status write, refused addresses
    apb(1'b1, 8'h24, 32'h3ffff);
    foreach (ra[i]) begin
      apb(1'b0, ra[i], 32'h0);
      chk(rd, 32'h0);
      chk(32'(er), 32'(ra[i] == 8'hc0 || ra[i] == 8'h41));
    end
    // prescaled counting, with and without staggering
    for (int i = 0; i < 4; i++) begin
      p  = $urandom % 4;
      st = (i == 0) ? 1 : $urandom % 2;
      apb(1'b1, 8'h20, 32'(st));
      apb(1'b1, 8'h00, 32'(p * 8 + 1));
      apb(1'b0, 8'h04, 32'h0);
      c = rd[15:0];
      repeat (60) @(posedge clock);
      apb(1'b0, 8'h04, 32'h0);
      chk(32'(rd[15:0] - c), 32'(exp_steps(p, st)));
    end
    apb(1'b1, 8'h00, 32'h0);
    // time base 1 counts rising edges of its count input
    apb(1'b1, 8'h10, 32'h5);
    n = 1 + $urandom % 8;
    tick(n, 1);
    apb(1'b0, 8'h14, 32'h0);
    chk(rd, 32'(n));
    // short period from a random reload, all compare kinds on time base 0
    r  = 2 + $urandom % 4;
    rl = 16'hffff - 16'(r);
    apb(1'b1, 8'h08, 32'(rl));
    apb(1'b1, 8'h04, 32'(rl));
    for (int i = 0; i < 10; i++) begin
      apb(1'b1, 8'(8'h40 + 4 * chs[i]), 32'(cfgs[i]));
      apb(1'b1, 8'(8'h80 + 4 * chs[i]), (chs[i] % 9 == 0) ? 32'hffff : 32'(rl + 16'h1));
    end
    chk(32'(pin_oe & 16'h06e7), 32'h27);
    apb(1'b1, 8'h2c, 32'h8);
    apb(1'b1, 8'h00, 32'h3);
    tick(2 * (r + 1), 0);
    apb(1'b0, 8'h24, 32'h0);
    chk(rd, 32'h1023f);
    chk(32'(edges[0]), 32'h4);
    chk(32'(edges[1]), 32'h4);
    chk(32'(edges[2]), 32'h2);
    chk(32'(edges[5]), 32'h1);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'(rl));
    chk(32'(irq), 32'h1);
    // a second hit in one period: mode 0 repeats, mode 2 stays quiet
    tick(1, 0);
    apb(1'b1, 8'h28, 32'h3ffff);
    chk(32'(irq), 32'h0);
    apb(1'b1, 8'h04, 32'(rl));
    tick(1, 0);
    apb(1'b0, 8'h24, 32'h0);
    chk(32'(rd[4:3]), 32'h1);
    chk(32'(irq), 32'h1);
    apb(1'b1, 8'h2c, 32'h0);
    chk(32'(irq), 32'h0);
    // captures on rising, falling and both edges of a count stepped once between the edges
    c = 16'($urandom % 32'h8000);
    apb(1'b1, 8'h04, 32'(c));
    apb(1'b1, 8'h6c, 32'h9);
    drv <= 16'h0cc0;
    @(posedge clock);
    tick(1, 0);
    drv <= 16'h0000;
    repeat (2) @(posedge clock);
    apb(1'b0, 8'h98, 32'h0);
    chk(rd, 32'(c));
    apb(1'b0, 8'h9c, 32'h0);
    chk(rd, 32'(c + 16'h1));
    apb(1'b0, 8'ha8, 32'h0);
    chk(rd, 32'(c + 16'h1));
    // channel 11 captures the held count of time base 1
    apb(1'b0, 8'hac, 32'h0);
    chk(rd, 32'(n));
    apb(1'b0, 8'h24, 32'h0);
    chk(rd & 32'hcc0, 32'hcc0);
    wrap_up();
  end
endmodule : tb
`default_nettype wire
